// [pkg/lmra_pkg.sv]
// Shared constants for the mode register access block.
// Assumes a single core clock that oversamples the DRAM command clock.
package lmra_pkg;
   // Command opcodes on CA[4:0] in the cycle where chip select is high
   localparam logic [4:0] CMD_ACT = 5'h01;
   localparam logic [4:0] CMD_WR = 5'h04;
   localparam logic [4:0] CMD_MRW = 5'h06;
   localparam logic [4:0] CMD_MRR = 5'h0e;
   localparam logic [4:0] CMD_PRE = 5'h10;
   // Mode register space
   localparam int MR_AW = 6;
   localparam int MR_DW = 8;
   localparam int MR_COUNT = 64;
   localparam logic [7:0] MR_RESET = 8'h00;
   // Burst and latency defaults, in CK cycles or unit intervals
   localparam int MRR_BL = 16;
   localparam int MRR_DATA_UI = 4;
   localparam int RL_DEF = 14;
   localparam int WL_DEF = 8;
   localparam int WR_BL_DEF = 16;
   localparam int TWTR_CK_DEF = 4;
   // Bank state as seen at the outputs
   typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_MR_READ, BK_MR_WRITE} lmra_bank_t;
   typedef enum logic [2:0] {DEC_IDLE, DEC_MRR_MA, DEC_MRW_MA, DEC_MRW_D0, DEC_MRW_D1} lmra_dec_t;
endpackage

// [pkg/lmra_mr_if.sv]
// Port between the command logic and the mode register store.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface lmra_mr_if;
   logic wr_en;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic [5:0] rd_addr;
   logic [7:0] rd_data;
   modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// [core/lmra_mr_file.sv]
// Mode register store: 64 bytes in flip-flops, read-only entries masked.
// Assumes write strobes arrive already decoded on the core clock.
`timescale 1ns/1ps
`default_nettype none
module lmra_mr_file #(
   parameter logic [63:0] RO_MASK = 64'h0000_0000_0000_0000,
   parameter logic [7:0] RO_VALUE = 8'h00
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Store port
   lmra_mr_if.mem mr
);
   import lmra_pkg::*;

   logic [MR_DW-1:0] mem_r [MR_COUNT];

   // One flip-flop byte per entry; read-only entries never take a write
   genvar gi;
   generate
      for (gi = 0; gi < MR_COUNT; gi++) begin : g_ent
         always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
               mem_r[gi] <= RO_MASK[gi] ? RO_VALUE : MR_RESET;
            end else if (mr.wr_en && mr.wr_addr == 6'(gi) && !RO_MASK[gi]) begin
               mem_r[gi] <= mr.wr_data;
            end
         end
      end
   endgenerate

   // Read is combinational so the burst can latch it on its first edge
   assign mr.rd_data = mem_r[mr.rd_addr];

   ro_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      mr.wr_en && RO_MASK[mr.wr_addr] |=> mem_r[$past(mr.wr_addr)] == $past(mem_r[mr.wr_addr]))
      else $error("read-only mode register changed by a write");
endmodule
`default_nettype wire

// [core/lmra_top.sv]
// Mode register read/write command logic of the DRAM die.
// Assumes CK, CKE, CS and CA arrive asynchronously and are oversampled by core_clk_i.
//
// How it works
// - tWTR starts at CK rise after write data
// - MRW taken on CK rise, CA carries all
// - writes to read-only registers are ignored
// - MRR/MRW return to starting bank state
// - register data on DQ[7:0] first four UI
// - MRR burst is sixteen UI, uninterruptible
`timescale 1ns/1ps
`default_nettype none
module lmra_top #(
   parameter int RL = lmra_pkg::RL_DEF,
   parameter int WL = lmra_pkg::WL_DEF,
   parameter int WR_BL = lmra_pkg::WR_BL_DEF,
   parameter int TWTR_CK = lmra_pkg::TWTR_CK_DEF,
   parameter logic [63:0] RO_MASK = 64'h0000_0000_0000_0000,
   parameter logic [7:0] RO_VALUE = 8'h00
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Command pins
   input wire logic ck_i,
   input wire logic cke_i,
   input wire logic cs_i,
   input wire logic [5:0] ca_i,
   // Data pins, output side only
   output logic [15:0] dq_o,
   output logic dq_oe_o,
   output logic dqs_o,
   output logic dqs_oe_o,
   // Status
   output logic [1:0] bank_state_o,
   output logic wtr_busy_o
);
   import lmra_pkg::*;

   lmra_mr_if mr ();
   lmra_mr_file #(.RO_MASK(RO_MASK), .RO_VALUE(RO_VALUE)) u_mr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .mr(mr.mem)
   );

   logic ck_s1_r, ck_s2_r, ck_s3_r, cke_s1_r, cke_s2_r, cs_s1_r, cs_s2_r;
   logic [5:0] ca_s1_r, ca_s2_r;
   logic ck_rise, ck_fall, cmd_edge, cmd_hi;
   lmra_dec_t dec_r;
   lmra_bank_t bk_r;
   logic ret_active_r;
   logic [5:0] ma_r;
   logic [7:0] wdata_r;
   logic wr_en_r;
   logic lat_run_r, burst_r, burst_done;
   logic [5:0] lat_cnt_r;
   logic [3:0] ui_r;
   logic [7:0] rdata_r;
   logic [7:0] wr_cnt_r;
   logic wr_run_r;
   logic [7:0] wtr_cnt_r;

   // Every pin passes two flops; CK gets a third stage for edge finding
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         cke_s1_r <= 1'b0;
         cke_s2_r <= 1'b0;
         cs_s1_r <= 1'b0;
         cs_s2_r <= 1'b0;
         ca_s1_r <= 6'h00;
         ca_s2_r <= 6'h00;
      end else begin
         ck_s1_r <= ck_i;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         cke_s1_r <= cke_i;
         cke_s2_r <= cke_s1_r;
         cs_s1_r <= cs_i;
         cs_s2_r <= cs_s1_r;
         ca_s1_r <= ca_i;
         ca_s2_r <= ca_s1_r;
      end
   end

   // Same sync depth on all pins keeps CA aligned with the CK edge seen
   assign ck_rise = ck_s2_r && !ck_s3_r;
   assign ck_fall = !ck_s2_r && ck_s3_r;
   assign cmd_edge = ck_rise && cke_s2_r;
   assign cmd_hi = cmd_edge && cs_s2_r;

   // Command decoder: MRW is opcode, address, data low six, data high two
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         dec_r <= DEC_IDLE;
         ma_r <= 6'h00;
         wdata_r <= 8'h00;
         wr_en_r <= 1'b0;
      end else begin
         wr_en_r <= 1'b0;
         if (cmd_edge) begin
            case (dec_r)
               DEC_IDLE: begin
                  // A new MRR while one is in flight is dropped: no interruption
                  if (cs_s2_r && ca_s2_r[4:0] == CMD_MRR && !lat_run_r && !burst_r) begin
                     dec_r <= DEC_MRR_MA;
                  end else if (cs_s2_r && ca_s2_r[4:0] == CMD_MRW) begin
                     dec_r <= DEC_MRW_MA;
                  end
               end
               DEC_MRR_MA: begin
                  ma_r <= ca_s2_r;
                  dec_r <= DEC_IDLE;
               end
               DEC_MRW_MA: begin
                  ma_r <= ca_s2_r;
                  dec_r <= DEC_MRW_D0;
               end
               DEC_MRW_D0: begin
                  wdata_r[5:0] <= ca_s2_r;
                  dec_r <= DEC_MRW_D1;
               end
               DEC_MRW_D1: begin
                  wdata_r[7:6] <= ca_s2_r[1:0];
                  wr_en_r <= 1'b1;
                  dec_r <= DEC_IDLE;
               end
               default: dec_r <= DEC_IDLE;
            endcase
         end
      end
   end

   assign mr.wr_en = wr_en_r;
   assign mr.wr_addr = ma_r;
   assign mr.wr_data = wdata_r;
   assign mr.rd_addr = ma_r;
   // Sixteen UI that open on a rise close on the eighth rise after it
   assign burst_done = burst_r && (ck_rise || ck_fall) && ui_r == 4'(MRR_BL - 1);

   // Bank state; the MR states remember where they came from
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         bk_r <= BK_IDLE;
         ret_active_r <= 1'b0;
      end else begin
         case (bk_r)
            BK_IDLE, BK_ACTIVE: begin
               if (dec_r == DEC_MRR_MA && cmd_edge) begin
                  ret_active_r <= (bk_r == BK_ACTIVE);
                  bk_r <= BK_MR_READ;
               end else if (dec_r == DEC_MRW_MA && cmd_edge) begin
                  ret_active_r <= (bk_r == BK_ACTIVE);
                  bk_r <= BK_MR_WRITE;
               end else if (cmd_hi && ca_s2_r[4:0] == CMD_ACT) begin
                  bk_r <= BK_ACTIVE;
               end else if (cmd_hi && ca_s2_r[4:0] == CMD_PRE) begin
                  bk_r <= BK_IDLE;
               end
            end
            BK_MR_READ: begin
               if (burst_done) begin
                  bk_r <= ret_active_r ? BK_ACTIVE : BK_IDLE;
               end
            end
            BK_MR_WRITE: begin
               if (wr_en_r) begin
                  bk_r <= ret_active_r ? BK_ACTIVE : BK_IDLE;
               end
            end
            default: bk_r <= BK_IDLE;
         endcase
      end
   end

   assign bank_state_o = bk_r;

   // Read latency: count RL CK rises from the MRR address cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lat_run_r <= 1'b0;
         lat_cnt_r <= 6'h00;
      end else if (dec_r == DEC_MRR_MA && cmd_edge) begin
         lat_run_r <= 1'b1;
         lat_cnt_r <= 6'(RL - 1);
      end else if (lat_run_r && ck_rise) begin
         if (lat_cnt_r == 6'h00) begin
            lat_run_r <= 1'b0;
         end else begin
            lat_cnt_r <= lat_cnt_r - 6'h01;
         end
      end
   end

   // Burst: one UI per CK edge, sixteen UI, DQS toggling every UI
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         burst_r <= 1'b0;
         ui_r <= 4'h0;
         rdata_r <= 8'h00;
         dq_o <= 16'h0000;
         dq_oe_o <= 1'b0;
         dqs_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end else if (lat_run_r && ck_rise && lat_cnt_r == 6'h00) begin
         burst_r <= 1'b1;
         ui_r <= 4'h0;
         rdata_r <= mr.rd_data;
         dq_o <= {8'h00, mr.rd_data};
         dq_oe_o <= 1'b1;
         dqs_o <= 1'b1;
         dqs_oe_o <= 1'b1;
      end else if (burst_done) begin
         burst_r <= 1'b0;
         dq_o <= 16'h0000;
         dq_oe_o <= 1'b0;
         dqs_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end else if (burst_r && (ck_rise || ck_fall)) begin
         ui_r <= ui_r + 4'h1;
         dqs_o <= !dqs_o;
         // Later UI are defined as don't-care; zeros keep the bus quiet
         dq_o <= (ui_r + 4'h1 < 4'(MRR_DATA_UI)) ? {8'h00, rdata_r} : 16'h0000;
      end
   end

   // Write tracking: the tWTR window opens on the CK rise after the last
   // data edge, so the internal bus turns round before MRR data leaves
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_run_r <= 1'b0;
         wr_cnt_r <= 8'h00;
         wtr_cnt_r <= 8'h00;
         wtr_busy_o <= 1'b0;
      end else begin
         if (cmd_hi && ca_s2_r[4:0] == CMD_WR) begin
            wr_run_r <= 1'b1;
            wr_cnt_r <= 8'(WL + WR_BL / 2);
         end else if (wr_run_r && ck_rise) begin
            if (wr_cnt_r == 8'h00) begin
               wr_run_r <= 1'b0;
               wtr_cnt_r <= 8'(TWTR_CK);
               wtr_busy_o <= 1'b1;
            end else begin
               wr_cnt_r <= wr_cnt_r - 8'h01;
            end
         end
         if (wtr_busy_o && ck_rise && !(wr_run_r && wr_cnt_r == 8'h00)) begin
            wtr_cnt_r <= wtr_cnt_r - 8'h01;
            if (wtr_cnt_r == 8'h01) begin
               wtr_busy_o <= 1'b0;
            end
         end
      end
   end

   mrw_edge_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(wr_en_r) |-> $past(ck_rise) && $past(cke_s2_r))
      else $error("mode register write not tied to a CK rise with CKE high");

   burst_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(dq_oe_o) |-> $past(ui_r) == 4'hf && $past(dqs_o) == 1'b0)
      else $error("MRR burst did not run sixteen UI");

   upper_dq_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      dq_oe_o && ui_r < 4'h4 |-> dq_o == {8'h00, rdata_r})
      else $error("MRR data missing from the first four UI");

   rd_return_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $past(bk_r) == BK_MR_READ && bk_r != BK_MR_READ |->
      bk_r == (ret_active_r ? BK_ACTIVE : BK_IDLE) && !dq_oe_o)
      else $error("MRR left the bank in a different state");

   wr_return_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $past(wr_en_r) && $past(bk_r) == BK_MR_WRITE |-> bk_r != BK_MR_WRITE)
      else $error("MRW did not return to the bank state");

   wtr_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(wtr_busy_o) |-> $past(ck_rise) && wtr_cnt_r == 8'(TWTR_CK))
      else $error("tWTR window did not open on a CK rise");
endmodule
`default_nettype wire

// [tb/lmra_ctl_model.sv]
// Controller model that drives the command pins of the mode register block.
// Assumes every task is entered at a rising edge of the core clock.
`timescale 1ns/1ps
`default_nettype none
module lmra_ctl_model
   import lmra_pkg::*;
#(
   parameter int RL = RL_DEF,
   parameter int WL = WL_DEF,
   parameter int WR_BL = WR_BL_DEF,
   parameter int TWTR_CK = TWTR_CK_DEF,
   parameter int TMRW = 10
) (
   // Core clock
   input wire logic core_clk_i,
   // Command pins
   output logic ck_o,
   output logic cke_o,
   output logic cs_o,
   output logic [5:0] ca_o
);
   // CK stands low between frames; CKE starts high and none of these tasks drops it
   initial begin
      ck_o = 1'b0;
      cke_o = 1'b1;
      cs_o = 1'b0;
      ca_o = 6'h00;
   end
   // One CK period of 8 core cycles; pins move with the falling CK
   task automatic cyc(input logic cs, input logic [5:0] ca);
      cs_o <= cs;
      ca_o <= ca;
      repeat (4) @(posedge core_clk_i);
      ck_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      ck_o <= 1'b0;
   endtask
   // Deselect; CA flips each cycle so a stale value never looks valid
   task automatic des(input int n);
      repeat (n) cyc(1'b0, ~ca_o);
   endtask
   task automatic mrw(input logic [5:0] ma, input logic [7:0] d);
      cyc(1'b1, {1'b0, CMD_MRW});
      cyc(1'b0, ma);
      cyc(1'b0, d[5:0]);
      cyc(1'b0, {4'h0, d[7:6]});
      des(TMRW);
   endtask
   // Long tail covers MRR to MRR, MRW and write spacing
   task automatic mrr(input logic [5:0] ma);
      cyc(1'b1, {1'b0, CMD_MRR});
      cyc(1'b0, ma);
      des(RL + 12);
   endtask
   task automatic wr();
      cyc(1'b1, {1'b0, CMD_WR});
      des(WL + WR_BL / 2 + 1 + TWTR_CK + 2);
   endtask
   // No reads are issued, so read spacing holds trivially
   task automatic bank(input logic [4:0] op);
      cyc(1'b1, {1'b0, op});
      des(4);
   endtask
endmodule
`default_nettype wire

// [tb/test_mode_register_access_timing.sv]
// Self-checking bench for the mode register access block.
// Assumes the controller model sits on the command pins.
`timescale 1ns/1ps
`default_nettype none
module test_mode_register_access_timing;
   import lmra_pkg::*;
   localparam logic [63:0] RO_M = 64'h0000_0000_0000_0100;
   localparam logic [7:0] RO_V = 8'h00;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ck, cke, cs, dq_oe, dqs, dqs_oe, wtr_busy, oe_q, dqs_q, wtr_q;
   logic saw_rd, saw_wr, oe_bad, hi_bad, dqs_bad;
   logic [5:0] ca;
   logic [15:0] dq;
   logic [1:0] bank_state;
   logic [7:0] ui_data [0:31];
   int fails = 0;
   int num_checks = 0;
   int ui_cnt = 0;
   int cyc_n = 0;
   int wtr_rise = 0;
   int wtr_len = 0;
   always #25 core_clk_i = ~core_clk_i;
   lmra_ctl_model u_ctl (.core_clk_i(core_clk_i), .ck_o(ck), .cke_o(cke), .cs_o(cs), .ca_o(ca));
   lmra_top #(.RO_MASK(RO_M), .RO_VALUE(RO_V)) u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .ck_i(ck), .cke_i(cke), .cs_i(cs), .ca_i(ca), .dq_o(dq), .dq_oe_o(dq_oe), .dqs_o(dqs),
      .dqs_oe_o(dqs_oe), .bank_state_o(bank_state), .wtr_busy_o(wtr_busy));
   // Monitor: one UI per strobe change while the device drives
   always @(posedge core_clk_i) begin
      cyc_n <= cyc_n + 1;
      oe_q <= dq_oe;
      dqs_q <= dqs;
      wtr_q <= wtr_busy;
      if (dq_oe === 1'b1 && (oe_q !== 1'b1 || dqs !== dqs_q)) begin
         ui_data[ui_cnt[4:0]] <= dq[7:0];
         ui_cnt <= ui_cnt + 1;
      end
      if (dqs_oe !== dq_oe) oe_bad <= 1'b1;
      // Upper byte lane carries no register data
      if (dq_oe === 1'b1 && dq[15:8] !== 8'h00) hi_bad <= 1'b1;
      // Strobe must be high in the first UI
      if (dq_oe === 1'b1 && oe_q !== 1'b1 && dqs !== 1'b1) dqs_bad <= 1'b1;
      if (bank_state === 2'h2) saw_rd <= 1'b1;
      if (bank_state === 2'h3) saw_wr <= 1'b1;
      if (wtr_busy === 1'b1) wtr_len <= wtr_len + 1;
      if (wtr_busy === 1'b1 && wtr_q !== 1'b1) wtr_rise <= cyc_n;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Clears the capture so a missing burst cannot pass on old data
   task automatic clr();
      for (int i = 0; i < 5; i++) ui_data[i] = 8'hxx;
      ui_cnt = 0;
      saw_rd = 1'b0;
      saw_wr = 1'b0;
      oe_bad = 1'b0;
      hi_bad = 1'b0;
      dqs_bad = 1'b0;
   endtask
   task automatic rd_check(input logic [5:0] ma, input logic [7:0] exp);
      clr();
      u_ctl.mrr(ma);
      check("ui count", 16'(ui_cnt), 16'd16);
      check("strobe enable", {15'h0, oe_bad}, 16'h0000);
      check("strobe first ui", {15'h0, dqs_bad}, 16'h0000);
      check("upper dq", {15'h0, hi_bad}, 16'h0000);
      for (int i = 0; i < MRR_DATA_UI; i++) check("mr byte", {8'h00, ui_data[i]}, {8'h00, exp});
      check("undefined ui", {8'h00, ui_data[4]}, 16'h0000);
      check("reading state", {15'h0, saw_rd}, 16'h0001);
      check("oe released", {15'h0, dq_oe}, 16'h0000);
   endtask
   task automatic t_mrw_read();
      logic [5:0] ma [0:2] = '{6'h00, 6'h3f, 6'h11};
      logic [7:0] d [0:2] = '{8'hc5, 8'h3a, 8'hff};
      for (int i = 0; i < 3; i++) u_ctl.mrw(ma[i], d[i]);
      for (int i = 0; i < 3; i++) rd_check(ma[i], d[i]);
   endtask
   task automatic t_active();
      u_ctl.bank(CMD_ACT);
      check("active", {14'h0, bank_state}, 16'h0001);
      rd_check(6'h00, 8'hc5);
      check("back active", {14'h0, bank_state}, 16'h0001);
      clr();
      u_ctl.mrw(6'h01, 8'h12);
      check("writing state", {15'h0, saw_wr}, 16'h0001);
      check("active after mrw", {14'h0, bank_state}, 16'h0001);
      u_ctl.bank(CMD_PRE);
      check("idle", {14'h0, bank_state}, 16'h0000);
      rd_check(6'h01, 8'h12);
   endtask
   task automatic t_read_only();
      u_ctl.mrw(6'h08, 8'ha5);
      rd_check(6'h08, RO_V);
      // CKE low hides every CK rise, so this MRW must not land
      u_ctl.cke_o <= 1'b0;
      u_ctl.mrw(6'h11, 8'h5a);
      u_ctl.cke_o <= 1'b1;
      u_ctl.des(8);
      rd_check(6'h11, 8'hff);
   endtask
   // A second MRR during latency must not cut the first one short
   task automatic t_refuse();
      clr();
      u_ctl.cyc(1'b1, {1'b0, CMD_MRR});
      u_ctl.cyc(1'b0, 6'h3f);
      u_ctl.des(4);
      u_ctl.mrr(6'h00);
      check("ui count kept", 16'(ui_cnt), 16'd16);
      check("first byte kept", {8'h00, ui_data[0]}, 16'h003a);
   endtask
   task automatic t_wtr();
      int t0;
      int e;
      t0 = cyc_n;
      e = 8 + 8 * (WL_DEF + WR_BL_DEF / 2 + 1);
      wtr_len = 0;
      u_ctl.wr();
      check("wtr start", 16'(wtr_rise - t0 >= e - 3 && wtr_rise - t0 <= e + 3), 16'h0001);
      e = 8 * TWTR_CK_DEF;
      check("wtr length", 16'(wtr_len >= e - 2 && wtr_len <= e + 2), 16'h0001);
      rd_check(6'h11, 8'hff);
   endtask
   initial begin
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      check("reset bank", {14'h0, bank_state}, 16'h0000);
      check("reset oe", {14'h0, dq_oe, wtr_busy}, 16'h0000);
      t_mrw_read();
      t_read_only();
      t_active();
      t_refuse();
      t_wtr();
      finish_test();
   end
   // Watchdog well beyond the few thousand cycles the tests take
   initial begin
      repeat (30000) @(posedge core_clk_i);
      fails++;
      finish_test();
   end
endmodule
`default_nettype wire
